// >>> hdl/fdc_defs.svh
`ifndef FDC_DEFS_SVH
`define FDC_DEFS_SVH

// Instruction word field positions
`define FDC_OPC_HI 31
`define FDC_OPC_LO 26
`define FDC_FMT_HI 25
`define FDC_FMT_LO 21
`define FDC_CC_HI 20
`define FDC_CC_LO 18
`define FDC_TF_BIT 16
`define FDC_FN_HI 5
`define FDC_FN_LO 0

// Major opcode slots
`define FDC_OPC_SPECIAL 6'h00
`define FDC_OPC_FPU 6'h11
`define FDC_OPC_FPU_IDX 6'h13

// Format field values
`define FDC_FMT_S 5'h10
`define FDC_FMT_D 5'h11
`define FDC_FMT_L 5'h15

// Function rows (bits 5..3) and columns (bits 2..0)
`define FDC_ROW_0 3'h0
`define FDC_ROW_1 3'h1
`define FDC_ROW_2 3'h2
`define FDC_ROW_3 3'h3
`define FDC_ROW_4 3'h4
`define FDC_ROW_5 3'h5
`define FDC_ROW_6 3'h6
`define FDC_ROW_7 3'h7
`define FDC_COL_0 3'h0
`define FDC_COL_1 3'h1
`define FDC_COL_2 3'h2
`define FDC_COL_3 3'h3
`define FDC_COL_5 3'h5
`define FDC_COL_6 3'h6
`define FDC_COL_7 3'h7

// Integer conditional-move class function under the special opcode
`define FDC_FN_INT_CMOV 6'h01

// Reset values
`define FDC_RST_COND 4'h0
`define FDC_RST_CC 3'h0

`endif

// >>> hdl/fdc_pkg.sv
package fdc_pkg;

  typedef enum logic [4:0] {
    FDC_OP_NONE,
    FDC_OP_FOREIGN,
    FDC_OP_RESERVED,
    FDC_OP_CONVERT_TO_SINGLE,
    FDC_OP_CONVERT_TO_DOUBLE,
    FDC_OP_FP_MOVE_ON_FALSE,
    FDC_OP_FP_MOVE_ON_TRUE,
    FDC_OP_FP_MOVE_IF_ZERO,
    FDC_OP_FP_MOVE_IF_NONZERO,
    FDC_OP_FP_RECIPROCAL_APPROX,
    FDC_OP_FP_FP_RECIPROCAL_APPROX_SQRT_APPROX,
    FDC_OP_FP_COMPARE,
    FDC_OP_FP_WORD_LOAD_INDEXED,
    FDC_OP_FP_DWORD_LOAD_INDEXED,
    FDC_OP_FP_WORD_STORE_INDEXED,
    FDC_OP_FP_DWORD_STORE_INDEXED,
    FDC_OP_PREFETCH_INDEXED,
    FDC_OP_FP_MUL_ADD,
    FDC_OP_FP_MUL_SUB,
    FDC_OP_FP_NEG_MUL_ADD,
    FDC_OP_FP_NEG_MUL_SUB,
    FDC_OP_INT_MOVE_ON_FALSE,
    FDC_OP_INT_MOVE_ON_TRUE
  } fdc_op_t;

  typedef enum logic {
    FDC_EXC_RESERVED_INSTR,
    FDC_EXC_UNIMPL_OPERATION
  } fdc_exc_t;

endpackage

// >>> hdl/fdc_decoder.sv
`include "fdc_defs.svh"
`timescale 1ns/1ns
`default_nettype none

module fdc_decoder #(
  parameter bit RESV_AS_UNIMPL = 1'b0
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic instr_valid,
  input wire logic [31:0] instr_word,
  output logic dec_valid,
  output var fdc_pkg::fdc_op_t dec_op,
  output logic dec_double,
  output logic [3:0] dec_cmp_cond,
  output logic [2:0] dec_cc_sel,
  output logic dec_exc,
  output var fdc_pkg::fdc_exc_t dec_exc_kind
);
  import fdc_pkg::*;

  localparam fdc_exc_t EXC_KIND = RESV_AS_UNIMPL ?
    FDC_EXC_UNIMPL_OPERATION : FDC_EXC_RESERVED_INSTR;

  logic [5:0] opc;
  logic [4:0] fmt;
  logic [5:0] fn;
  logic [2:0] row;
  logic [2:0] col;
  logic sense;
  logic [2:0] cc;

  logic valid_reg;
  logic valid_next;
  fdc_op_t op_reg;
  fdc_op_t op_next;
  logic double_reg;
  logic double_next;
  logic [3:0] cond_reg;
  logic [3:0] cond_next;
  logic [2:0] cc_reg;
  logic [2:0] cc_next;
  logic exc_reg;
  logic exc_next;

  assign opc = instr_word[`FDC_OPC_HI:`FDC_OPC_LO];
  assign fmt = instr_word[`FDC_FMT_HI:`FDC_FMT_LO];
  assign fn = instr_word[`FDC_FN_HI:`FDC_FN_LO];
  assign row = fn[5:3];
  assign col = fn[2:0];
  assign sense = instr_word[`FDC_TF_BIT];
  assign cc = instr_word[`FDC_CC_HI:`FDC_CC_LO];

  always_comb
  begin
    fdc_op_t op;
    op = FDC_OP_FOREIGN;
    double_next = 1'b0;
    cond_next = `FDC_RST_COND;
    cc_next = `FDC_RST_CC;
    if (opc == `FDC_OPC_FPU)
    begin
      if (fmt == `FDC_FMT_L)
      begin
        if (row == `FDC_ROW_4 && col == `FDC_COL_0)
          op = FDC_OP_CONVERT_TO_SINGLE;
        else if (row == `FDC_ROW_4 && col == `FDC_COL_1)
        begin
          op = FDC_OP_CONVERT_TO_DOUBLE;
          double_next = 1'b1;
        end
        else if (row == `FDC_ROW_4 || row == `FDC_ROW_5)
          op = FDC_OP_RESERVED;
      end
      else if (fmt == `FDC_FMT_S || fmt == `FDC_FMT_D)
      begin
        double_next = (fmt == `FDC_FMT_D);
        if (row == `FDC_ROW_2)
        begin
          unique case (col)
            `FDC_COL_1:
            begin
              // Class slot: the sense bit resolves the move
              op = sense ? FDC_OP_FP_MOVE_ON_TRUE :
                FDC_OP_FP_MOVE_ON_FALSE;
              cc_next = cc;
            end
            `FDC_COL_2: op = FDC_OP_FP_MOVE_IF_ZERO;
            `FDC_COL_3: op = FDC_OP_FP_MOVE_IF_NONZERO;
            `FDC_COL_5: op = FDC_OP_FP_RECIPROCAL_APPROX;
            `FDC_COL_6: op = FDC_OP_FP_FP_RECIPROCAL_APPROX_SQRT_APPROX;
            default: op = FDC_OP_FOREIGN;
          endcase
        end
        else if (row == `FDC_ROW_6 || row == `FDC_ROW_7)
        begin
          op = FDC_OP_FP_COMPARE;
          cond_next = fn[3:0];
          cc_next = instr_word[10:8];
        end
      end
    end
    else if (opc == `FDC_OPC_FPU_IDX)
    begin
      unique case (row)
        `FDC_ROW_0:
          op = (col == `FDC_COL_0) ? FDC_OP_FP_WORD_LOAD_INDEXED :
               (col == `FDC_COL_1) ? FDC_OP_FP_DWORD_LOAD_INDEXED :
               FDC_OP_RESERVED;
        `FDC_ROW_1:
          op = (col == `FDC_COL_0) ? FDC_OP_FP_WORD_STORE_INDEXED :
               (col == `FDC_COL_1) ? FDC_OP_FP_DWORD_STORE_INDEXED :
               (col == `FDC_COL_7) ? FDC_OP_PREFETCH_INDEXED :
               FDC_OP_RESERVED;
        `FDC_ROW_2, `FDC_ROW_3: op = FDC_OP_RESERVED;
        `FDC_ROW_4: op = FDC_OP_FP_MUL_ADD;
        `FDC_ROW_5: op = FDC_OP_FP_MUL_SUB;
        `FDC_ROW_6: op = FDC_OP_FP_NEG_MUL_ADD;
        `FDC_ROW_7: op = FDC_OP_FP_NEG_MUL_SUB;
      endcase
      if (row[2])
      begin
        if (col == `FDC_COL_1)
          double_next = 1'b1;
        else if (col != `FDC_COL_0)
          op = FDC_OP_RESERVED;
      end
      else if (op == FDC_OP_FP_DWORD_LOAD_INDEXED ||
               op == FDC_OP_FP_DWORD_STORE_INDEXED)
        double_next = 1'b1;
    end
    else if (opc == `FDC_OPC_SPECIAL && fn == `FDC_FN_INT_CMOV)
    begin
      // Integer-register moves, distinct from the formatted FP moves
      op = sense ? FDC_OP_INT_MOVE_ON_TRUE :
        FDC_OP_INT_MOVE_ON_FALSE;
      cc_next = cc;
    end
    valid_next = instr_valid;
    op_next = instr_valid ? op : FDC_OP_NONE;
    // A reserved slot is issued as FDC_OP_RESERVED and flagged on dec_exc
    exc_next = instr_valid && (op == FDC_OP_RESERVED);
    if (!instr_valid)
    begin
      double_next = 1'b0;
      cond_next = `FDC_RST_COND;
      cc_next = `FDC_RST_CC;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      valid_reg <= 1'b0;
      op_reg <= FDC_OP_NONE;
      double_reg <= 1'b0;
      cond_reg <= `FDC_RST_COND;
      cc_reg <= `FDC_RST_CC;
      exc_reg <= 1'b0;
    end
    else
    begin
      valid_reg <= valid_next;
      op_reg <= op_next;
      double_reg <= double_next;
      cond_reg <= cond_next;
      cc_reg <= cc_next;
      exc_reg <= exc_next;
    end
  end

  assign dec_valid = valid_reg;
  assign dec_op = op_reg;
  assign dec_double = double_reg;
  assign dec_cmp_cond = cond_reg;
  assign dec_cc_sel = cc_reg;
  assign dec_exc = exc_reg;
  // Fixed per implementation by parameter
  assign dec_exc_kind = EXC_KIND;

endmodule

`default_nettype wire

// >>> sim/fdc_fetch_model.sv
`timescale 1ns/1ns
`default_nettype none
module fdc_fetch_model (
  input wire logic clk_sys,
  input wire logic req_valid,
  input wire logic [31:0] req_word,
  output logic instr_valid,
  output logic [31:0] instr_word
);
  logic [31:0] last_reg;
  always_ff @(posedge clk_sys)
    last_reg <= instr_word;
  // Idle slots carry the inverse of the prior slot's word, so every second idle slot repeats the last word
  assign instr_valid = req_valid;
  assign instr_word = req_valid ? req_word : ~last_reg;
endmodule
`default_nettype wire

// >>> sim/fdc_decoder_sva.sv
`timescale 1ns/1ns
`default_nettype none
module fdc_decoder_sva (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic instr_valid,
  input wire logic [31:0] instr_word,
  input wire logic dec_valid,
  input var fdc_pkg::fdc_op_t dec_op,
  input wire logic dec_double,
  input wire logic [3:0] dec_cmp_cond,
  input wire logic dec_exc
);
  import fdc_pkg::*;
  logic [5:0] fn;
  assign fn = instr_word[5:0];
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);
  sequence s_fpu_sd;
    instr_valid && instr_word[31:22] == 10'h118;
  endsequence
  AST_IDLE:
    assert property (!instr_valid |=> !dec_valid && dec_op == FDC_OP_NONE)
    else $error("result without word");
  AST_TAKE:
    assert property (instr_valid |=> dec_valid) else $error("word lost");
  AST_EXC:
    assert property (dec_exc == (dec_valid && dec_op == FDC_OP_RESERVED))
    else $error("exception mismatch");
  AST_CVT:
    assert property (instr_valid && instr_word[31:21] == 11'h235
      && fn[5:1] == 5'h10 |=> !dec_exc && dec_double == $past(fn[0]))
    else $error("bad convert");
  AST_CMP:
    assert property (s_fpu_sd ##0 fn[5:4] == 2'h3
      |=> dec_cmp_cond == $past(fn[3:0])) else $error("bad compare");
  AST_MOV:
    assert property (s_fpu_sd ##0 fn == 6'h11 |=> dec_op == ($past(
      instr_word[16]) ? FDC_OP_FP_MOVE_ON_TRUE : FDC_OP_FP_MOVE_ON_FALSE))
    else $error("bad fp move");
  AST_IDX:
    assert property (instr_valid && instr_word[31:26] == 6'h13
      && fn[2:1] != 2'h0 && fn != 6'h0F |=> dec_exc) else $error("ran slot");
  AST_FMA:
    assert property (instr_valid && instr_word[31:26] == 6'h13 && fn[5]
      && fn[2:1] == 2'h0 |=> !dec_exc && dec_double == $past(fn[0]))
    else $error("bad fused op");
endmodule
bind fdc_decoder fdc_decoder_sva u_sva (.clk_sys(clk_sys), .resetn(resetn),
  .instr_valid(instr_valid), .instr_word(instr_word), .dec_valid(dec_valid),
  .dec_op(dec_op), .dec_double(dec_double), .dec_cmp_cond(dec_cmp_cond),
  .dec_exc(dec_exc));
`default_nettype wire

// >>> sim/tb_fpu_rev4_opcode_decoder.sv
`timescale 1ns/1ns
`default_nettype none
module tb_fpu_rev4_opcode_decoder;
  import fdc_pkg::*;
  logic clk_sys = 1'b0, resetn = 1'b0, req_valid = 1'b0, pv = 1'b0;
  logic [31:0] req_word = 32'h0, instr_word, pw;
  logic instr_valid, dec_valid, dec_double, dec_exc;
  logic [3:0] dec_cmp_cond;
  logic [2:0] dec_cc_sel;
  fdc_op_t dec_op, e;
  fdc_exc_t dec_exc_kind;
  int mismatches = 0;
  int checked = 0;
  // Sweep heads: S twice, D twice, L, indexed, special twice
  logic [10:0] sweep [8] = '{11'h230, 11'h230, 11'h231, 11'h231,
    11'h235, 11'h260, 11'h000, 11'h000};
  fdc_fetch_model fetch (.clk_sys(clk_sys), .req_valid(req_valid),
    .req_word(req_word), .instr_valid(instr_valid), .instr_word(instr_word));
  fdc_decoder dut (.clk_sys(clk_sys), .resetn(resetn),
    .instr_valid(instr_valid), .instr_word(instr_word),
    .dec_valid(dec_valid), .dec_op(dec_op), .dec_double(dec_double),
    .dec_cmp_cond(dec_cmp_cond), .dec_cc_sel(dec_cc_sel),
    .dec_exc(dec_exc), .dec_exc_kind(dec_exc_kind));
  initial
    forever #4 clk_sys = ~clk_sys;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
      $display("ERROR %0t got %h want %h", $time, seen, exp);
    mismatches += int'(seen !== exp);
  endtask
  task automatic wrap_up;
    if (mismatches == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  function automatic fdc_op_t exp_op(input logic [31:0] w);
    logic [5:0] f;
    f = w[5:0];
    exp_op = FDC_OP_FOREIGN;
    if (w[31:26] == 6'h00 && f == 6'h01)
      exp_op = fdc_op_t'(FDC_OP_INT_MOVE_ON_FALSE + w[16]);
    if (w[31:26] == 6'h13)
      exp_op = f[5] ? (f[2:1] ? FDC_OP_RESERVED
        : fdc_op_t'(FDC_OP_FP_MUL_ADD + f[4:3]))
        : f == 6'h0F ? FDC_OP_PREFETCH_INDEXED
        : f[4] || f[2:1] ? FDC_OP_RESERVED
        : fdc_op_t'(FDC_OP_FP_WORD_LOAD_INDEXED + {f[3], f[0]});
    if (w[31:21] == 11'h235 && f[5:4] == 2'h2)
      exp_op = f[3:1] ? FDC_OP_RESERVED
        : fdc_op_t'(FDC_OP_CONVERT_TO_SINGLE + f[0]);
    if (w[31:22] == 10'h118)
      exp_op = f[5:4] == 2'h3 ? FDC_OP_FP_COMPARE
        : f == 6'h11 ? fdc_op_t'(FDC_OP_FP_MOVE_ON_FALSE + w[16])
        : f == 6'h12 || f == 6'h13
        ? fdc_op_t'(FDC_OP_FP_MOVE_IF_ZERO + f[0])
        : f == 6'h15 || f == 6'h16
        ? fdc_op_t'(FDC_OP_FP_RECIPROCAL_APPROX + f[1]) : FDC_OP_FOREIGN;
  endfunction
  function automatic logic exp_dbl(input logic [31:0] w);
    logic [5:0] f;
    f = w[5:0];
    exp_dbl = 1'b0;
    if (w[31:22] == 10'h118)
      exp_dbl = w[21];
    if (w[31:21] == 11'h235)
      exp_dbl = (f == 6'h21);
    if (w[31:26] == 6'h13)
      exp_dbl = f[5] ? (f[2:0] == 3'h1) : (f == 6'h01 || f == 6'h09);
  endfunction
  function automatic logic [2:0] exp_cc(input fdc_op_t o,
    input logic [31:0] w);
    exp_cc = 3'h0;
    if (o == FDC_OP_FP_MOVE_ON_FALSE || o == FDC_OP_FP_MOVE_ON_TRUE ||
        o == FDC_OP_INT_MOVE_ON_FALSE || o == FDC_OP_INT_MOVE_ON_TRUE)
      exp_cc = w[20:18];
    if (o == FDC_OP_FP_COMPARE)
      exp_cc = w[10:8];
  endfunction
  initial
  begin
    void'($urandom(32'h168a));
    repeat (8) @(posedge clk_sys);
    #1 resetn = 1'b1;
    check(dec_exc_kind, FDC_EXC_RESERVED_INSTR);
    for (int i = 0; i < 900; i++)
    begin
      @(posedge clk_sys);
      #1 e = pv ? exp_op(pw) : FDC_OP_NONE;
      check(dec_valid, pv);
      check(dec_op, e);
      check(dec_exc, e == FDC_OP_RESERVED);
      check(dec_cmp_cond, e == FDC_OP_FP_COMPARE ? pw[3:0] : 4'h0);
      check(dec_double, pv && exp_dbl(pw));
      check(dec_cc_sel, pv ? exp_cc(e, pw) : 3'h0);
      pv = i < 512 || $urandom_range(3) > 0;
      pw = $urandom;
      if (i < 512)
        {pw[31:21], pw[16], pw[5:0]} = {sweep[i[8:6]], i[6:0]};
      else if (pw[31])
        pw[31:22] = pw[30] ? 10'h118 : {6'h13, pw[25:22]};
      req_valid = pv;
      req_word = pw;
    end
    wrap_up();
  end
endmodule
`default_nettype wire
